// ### rtl/cpu_mode_and_event_vectoring.sv
`default_nettype none

module cpu_mode_and_event_vectoring (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Condition flags from the datapath
	input wire logic flag_we,
	input wire logic [cmev_pkg::FLAG_W-1:0] flag_in,
	// Current instruction context
	input wire logic [31:0] cur_pc,
	// Exceptions
	input wire logic unrec_exc,
	input wire logic bus_err_data,
	input wire logic bus_err_fetch,
	input wire logic [31:0] bus_err_addr,
	input wire logic exc_req,
	input wire logic [cmev_pkg::VEC_OFF_W-1:0] exc_offset,
	// Interrupt controller
	input wire logic nmi_req,
	input wire logic [3:0] irq_req,
	input wire logic [cmev_pkg::VEC_OFF_W-1:0] irq_offset,
	output logic irq_ack,
	output logic [3:0] irq_ack_level,
	// Debug
	input wire logic dbg_req,
	input wire logic [31:0] dbg_handler,
	input wire logic retd_exec,
	// Event return
	input wire logic ret_exec,
	input wire logic [31:0] ret_status,
	input wire logic [31:0] ret_pc,
	// System register move port
	input wire logic sys_req,
	input wire logic sys_write,
	input wire logic [cmev_pkg::SYS_ADDR_W-1:0] sys_addr,
	input wire logic [31:0] sys_wdata,
	output logic [31:0] sys_rdata,
	output logic sys_done,
	output logic sys_fault,
	// Fetch redirect and stack push
	output logic redirect_valid,
	output logic [31:0] redirect_pc,
	output logic push_valid,
	output logic [31:0] push_status,
	output logic [31:0] push_pc,
	// State
	output logic [31:0] status_word,
	output logic privileged,
	output logic count_match
);
	import cmev_pkg::*;

	// ==========================================================
	// Reset release
	logic rst_meta;
	logic rst_sync_b;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_b <= rst_meta;
		end
	end

	// ==========================================================
	// Registers
	logic [31:0] event_vector_base;
	logic [31:0] app_call_base;
	logic [31:0] core_control;
	logic [31:0] exception_cause;
	logic [31:0] debug_return_status;
	logic [31:0] debug_return_pc;
	logic [31:0] cycle_counter;
	logic [31:0] cycle_compare;
	logic [31:0] bus_fault_address;
	logic boot_pending;

	// ==========================================================
	// Event selection
	logic [2:0] cur_mode;
	logic [2:0] cur_rank;
	logic in_debug;
	logic priv_now;
	logic [N_SRC-1:0] src_req;
	logic [N_SRC-1:0] src_grant;
	logic src_any;
	logic dbg_take;
	logic retd_take;
	logic ev_take;
	logic [2:0] next_mode;
	logic [31:0] next_mask_set;
	logic [13:0] next_offset;
	logic [3:0] next_ack_level;

	assign cur_mode = status_word[MODE_LSB +: 3];
	assign cur_rank = cmev_mode_rank(cur_mode);
	assign in_debug = status_word[BIT_D];
	assign priv_now = (cur_mode != MODE_APP) || in_debug; // RULE5 RULE7

	always_comb begin
		src_req = '0;
		src_req[SRC_UNREC] = unrec_exc;
		src_req[SRC_BERR_D] = bus_err_data;
		src_req[SRC_BERR_I] = bus_err_fetch;
		src_req[SRC_NMI] = nmi_req && (cmev_mode_rank(MODE_NMI) < cur_rank); // RULE4
		src_req[SRC_EXC] = exc_req && !status_word[BIT_EM];
		for (int k = 0; k < 4; k++) begin
			src_req[SRC_INT3 + k] = irq_req[3 - k] && !status_word[BIT_GM] // RULE4
				&& !status_word[BIT_I0M + 3 - k]
				&& (cmev_mode_rank(3'(MODE_INT3 - k)) < cur_rank);
		end
	end

	cmev_prio_pick #(
		.N(N_SRC)
	) u_pick (
		.req(src_req),
		.any(src_any),
		.grant(src_grant)
	);

	assign retd_take = retd_exec && in_debug; // RULE9
	assign dbg_take = dbg_req && !in_debug && !status_word[BIT_DM] && !boot_pending;
	assign ev_take = src_any && !retd_take && !dbg_take && !boot_pending; // RULE19

	// Mode, mask set and offset of the granted source
	always_comb begin
		next_mode = MODE_EXC;
		next_mask_set = '0;
		next_offset = '0;
		next_ack_level = '0;
		for (int i = 0; i < N_SRC; i++) begin
			if (src_grant[i]) begin
				if (i >= SRC_INT3) begin
					next_mode = 3'(MODE_INT3 - (i - SRC_INT3)); // RULE3
					next_offset = irq_offset; // RULE16 RULE18
					next_ack_level = 4'h8 >> (i - SRC_INT3);
					for (int k = 0; k <= 3 - (i - SRC_INT3); k++) begin
						next_mask_set[BIT_I0M + k] = 1'b1; // RULE20
					end
				end else begin
					next_mode = (i == SRC_NMI) ? MODE_NMI : MODE_EXC; // RULE3
					next_mask_set = IRQ_MASK_ALL; // RULE20
					next_mask_set[BIT_GM] = 1'b1;
					next_mask_set[BIT_EM] = 1'b1;
					unique case (i)
						SRC_UNREC: next_offset = OFF_UNREC; // RULE15
						SRC_BERR_D: next_offset = OFF_BERR_D;
						SRC_BERR_I: next_offset = OFF_BERR_I;
						SRC_NMI: next_offset = OFF_NMI;
						default: next_offset = exc_offset; // RULE14
					endcase
				end
			end
		end
	end

	// ==========================================================
	// System register access decode
	logic acc_bad_align;
	logic acc_is_status;
	logic acc_ok;
	logic acc_wr_ok;
	logic [31:0] next_rdata;

	assign acc_bad_align = sys_addr[1:0] != 2'h0;
	assign acc_is_status = sys_addr == ADDR_STATUS;
	assign acc_ok = sys_req && !acc_bad_align && (priv_now || acc_is_status); // RULE5 RULE10
	assign acc_wr_ok = acc_ok && sys_write;

	always_comb begin
		next_rdata = '0;
		unique case (sys_addr)
			ADDR_STATUS: next_rdata = priv_now ? status_word : (status_word & STATUS_LOW_MASK);
			ADDR_EVBASE: next_rdata = event_vector_base;
			ADDR_CALLBASE: next_rdata = app_call_base;
			ADDR_CTRL: next_rdata = core_control;
			ADDR_CAUSE: next_rdata = exception_cause;
			ADDR_DBG_STATUS: next_rdata = debug_return_status; // RULE11
			ADDR_DBG_PC: next_rdata = debug_return_pc;
			ADDR_CFG0: next_rdata = CFG0_VALUE; // RULE12
			ADDR_CFG1: next_rdata = CFG1_VALUE;
			ADDR_COUNT: next_rdata = cycle_counter;
			ADDR_COMPARE: next_rdata = cycle_compare;
			ADDR_BUS_FAULT: next_rdata = bus_fault_address;
			default: next_rdata = '0; // RULE13
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			sys_rdata <= '0;
			sys_done <= 1'b0;
			sys_fault <= 1'b0;
		end else begin
			sys_done <= acc_ok;
			sys_fault <= sys_req && !acc_ok; // RULE5
			if (acc_ok && !sys_write) begin
				sys_rdata <= next_rdata; // RULE10
			end
		end
	end

	// ==========================================================
	// Status word
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			status_word <= STATUS_RESET; // RULE1 RULE2 RULE6
		end else if (retd_take) begin
			status_word <= debug_return_status & STATUS_USED_MASK; // RULE9
		end else if (dbg_take) begin
			status_word <= status_word | IRQ_MASK_ALL; // RULE8
			status_word[BIT_D] <= 1'b1;
			status_word[MODE_LSB +: 3] <= MODE_EXC;
		end else if (ev_take) begin
			status_word <= status_word | next_mask_set; // RULE20
			status_word[MODE_LSB +: 3] <= next_mode; // RULE3
		end else if (ret_exec) begin
			status_word <= (ret_status & STATUS_USED_MASK) | (status_word & (32'h1 << BIT_D));
		end else if (acc_wr_ok && acc_is_status) begin
			if (priv_now) begin
				status_word <= (sys_wdata & STATUS_USED_MASK) | (status_word & (32'h1 << BIT_D));
			end else begin
				status_word[15:0] <= sys_wdata[15:0] & STATUS_USED_MASK[15:0]; // RULE5
			end
		end else if (flag_we) begin
			status_word[BIT_C +: FLAG_W] <= flag_in; // RULE1
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			privileged <= 1'b1;
		end else begin
			privileged <= (status_word[MODE_LSB +: 3] != MODE_APP) || status_word[BIT_D];
		end
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			event_vector_base <= '0;
			app_call_base <= '0;
			core_control <= '0;
			cycle_compare <= '0;
		end else if (acc_wr_ok) begin
			unique case (sys_addr)
				ADDR_EVBASE: event_vector_base <= sys_wdata; // RULE12
				ADDR_CALLBASE: app_call_base <= sys_wdata;
				ADDR_CTRL: core_control <= sys_wdata;
				ADDR_COMPARE: cycle_compare <= sys_wdata;
				default: ;
			endcase
		end
	end

	// Debug return registers
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			debug_return_status <= '0;
			debug_return_pc <= '0;
		end else if (dbg_take) begin
			debug_return_status <= status_word; // RULE11
			debug_return_pc <= cur_pc;
		end else if (acc_wr_ok && sys_addr == ADDR_DBG_STATUS) begin
			debug_return_status <= sys_wdata; // RULE7
		end else if (acc_wr_ok && sys_addr == ADDR_DBG_PC) begin
			debug_return_pc <= sys_wdata;
		end
	end

	// Cause and bus fault capture
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			exception_cause <= '0;
			bus_fault_address <= '0;
		end else if (ev_take && !src_grant[SRC_NMI] && (src_grant[SRC_INT3 +: 4] == 4'h0)) begin
			exception_cause <= {18'h0, next_offset};
			if (src_grant[SRC_BERR_D] || src_grant[SRC_BERR_I]) begin
				bus_fault_address <= bus_err_addr;
			end
		end
	end

	// Cycle counter and compare match
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cycle_counter <= '0;
		end else if (acc_wr_ok && sys_addr == ADDR_COUNT) begin
			cycle_counter <= sys_wdata;
		end else begin
			cycle_counter <= cycle_counter + 32'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			count_match <= 1'b0;
		end else if (cycle_counter == cycle_compare && cycle_compare != 32'h0) begin
			count_match <= 1'b1;
		end else if (acc_wr_ok && sys_addr == ADDR_COMPARE) begin
			count_match <= 1'b0;
		end
	end

	// ==========================================================
	// Redirect, stack push and acknowledge
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			boot_pending <= 1'b1;
			redirect_valid <= 1'b0;
			redirect_pc <= '0;
		end else if (boot_pending) begin
			boot_pending <= 1'b0;
			redirect_valid <= 1'b1;
			redirect_pc <= RESET_ADDR; // RULE21
		end else if (retd_take) begin
			redirect_valid <= 1'b1;
			redirect_pc <= debug_return_pc; // RULE9
		end else if (dbg_take) begin
			redirect_valid <= 1'b1;
			redirect_pc <= dbg_handler;
		end else if (ev_take) begin
			redirect_valid <= 1'b1;
			redirect_pc <= event_vector_base | {18'h0, next_offset}; // RULE14 RULE17
		end else if (ret_exec) begin
			redirect_valid <= 1'b1;
			redirect_pc <= ret_pc;
		end else begin
			redirect_valid <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			push_valid <= 1'b0;
			push_status <= '0;
			push_pc <= '0;
			irq_ack <= 1'b0;
			irq_ack_level <= '0;
		end else begin
			push_valid <= ev_take;
			irq_ack <= ev_take && (src_grant[SRC_INT3 +: 4] != 4'h0);
			irq_ack_level <= ev_take ? next_ack_level : 4'h0;
			if (ev_take) begin
				push_status <= status_word;
				push_pc <= cur_pc;
			end
		end
	end

endmodule

`default_nettype wire

// ### rtl/cmev_pkg.sv
// Functional notes
// RULE1: Status word halves: flags low, mode high
// RULE2: Whole low half of status clears on reset
// RULE3: Six ranked privileged modes plus supervisor and application
// RULE4: Only a higher ranked mode may pre-empt; unrecoverable and bus error events are taken in any mode
// RULE5: Application mode blocks system registers and upper status
// RULE6: Execution starts in supervisor mode after reset
// RULE7: Debug state grants full register and instruction access
// RULE8: Debug entry masks all interrupt levels
// RULE9: Only return-from-debug leaves debug state
// RULE10: System registers reached only by move instructions
// RULE11: Debug return status 48, return address 80
// RULE12: Fixed addresses for the remaining system registers
// RULE13: Reserved and implementation defined address ranges
// RULE14: Taken event redirects to handler at base-relative slot
// RULE15: Critical handlers get wider fixed offsets
// RULE16: Autovector offsets are fourteen bits wide
// RULE17: Handler address is base OR offset
// RULE18: Interrupt controller arbitrates and supplies autovector offset
// RULE19: Simultaneous events resolve by fixed source priority
// RULE20: Accepting an event masks equal and lower sources
// RULE21: Reset fetch starts at fixed boot address
`default_nettype none

package cmev_pkg;

	// ==========================================================
	// System register addresses
	localparam int SYS_ADDR_W = 10;
	localparam logic [9:0] ADDR_STATUS = 10'h000; // RULE12
	localparam logic [9:0] ADDR_EVBASE = 10'h004;
	localparam logic [9:0] ADDR_CALLBASE = 10'h008;
	localparam logic [9:0] ADDR_CTRL = 10'h00c;
	localparam logic [9:0] ADDR_CAUSE = 10'h010;
	localparam logic [9:0] ADDR_DBG_STATUS = 10'h030; // RULE11
	localparam logic [9:0] ADDR_DBG_PC = 10'h050; // RULE11
	localparam logic [9:0] ADDR_CFG0 = 10'h100;
	localparam logic [9:0] ADDR_CFG1 = 10'h104;
	localparam logic [9:0] ADDR_COUNT = 10'h108;
	localparam logic [9:0] ADDR_COMPARE = 10'h10c;
	localparam logic [9:0] ADDR_BUS_FAULT = 10'h13c;
	localparam logic [9:0] ADDR_RSV_A_LO = 10'h084; // RULE13
	localparam logic [9:0] ADDR_RSV_A_HI = 10'h0fc;
	localparam logic [9:0] ADDR_RSV_B_LO = 10'h168;
	localparam logic [9:0] ADDR_RSV_B_HI = 10'h2fc;
	localparam logic [9:0] ADDR_OWN_LO = 10'h300;
	localparam logic [9:0] ADDR_OWN_HI = 10'h3fc;

	// ==========================================================
	// Status word fields
	localparam int BIT_C = 0;
	localparam int BIT_Z = 1;
	localparam int BIT_N = 2;
	localparam int BIT_V = 3;
	localparam int BIT_Q = 4;
	localparam int BIT_L = 5;
	localparam int BIT_T = 14;
	localparam int BIT_R = 15;
	localparam int BIT_GM = 16;
	localparam int BIT_I0M = 17;
	localparam int BIT_EM = 21;
	localparam int MODE_LSB = 22;
	localparam int BIT_D = 26;
	localparam int BIT_DM = 27;
	localparam int FLAG_W = 5;
	localparam logic [31:0] STATUS_RESET = 32'h0061_0000;
	localparam logic [31:0] STATUS_LOW_MASK = 32'h0000_ffff;
	localparam logic [31:0] STATUS_USED_MASK = 32'h0ddf_c03f;
	localparam logic [31:0] IRQ_MASK_ALL = 32'h001e_0000;

	// ==========================================================
	// Execution modes
	localparam logic [2:0] MODE_APP = 3'h0;
	localparam logic [2:0] MODE_SUP = 3'h1;
	localparam logic [2:0] MODE_INT0 = 3'h2;
	localparam logic [2:0] MODE_INT1 = 3'h3;
	localparam logic [2:0] MODE_INT2 = 3'h4;
	localparam logic [2:0] MODE_INT3 = 3'h5;
	localparam logic [2:0] MODE_EXC = 3'h6;
	localparam logic [2:0] MODE_NMI = 3'h7;
	localparam logic [2:0] RANK_NONE = 3'h7;

	// ==========================================================
	// Event sources, highest priority first
	localparam int N_SRC = 9;
	localparam int SRC_UNREC = 0;
	localparam int SRC_BERR_D = 1;
	localparam int SRC_BERR_I = 2;
	localparam int SRC_NMI = 3;
	localparam int SRC_EXC = 4;
	localparam int SRC_INT3 = 5;
	localparam int VEC_OFF_W = 14;
	localparam logic [13:0] OFF_UNREC = 14'h0000;
	localparam logic [13:0] OFF_BERR_D = 14'h0008;
	localparam logic [13:0] OFF_BERR_I = 14'h000c;
	localparam logic [13:0] OFF_NMI = 14'h0010;
	localparam logic [31:0] RESET_ADDR = 32'h8000_0000;
	localparam logic [31:0] CFG0_VALUE = 32'h0000_0001; // Arbitrary value
	localparam logic [31:0] CFG1_VALUE = 32'h0000_0002; // Arbitrary value

	// Priority rank of a mode, 1 is highest, 7 means unranked
	function automatic logic [2:0] cmev_mode_rank(input logic [2:0] mode);
		unique case (mode)
			MODE_NMI: cmev_mode_rank = 3'h1;
			MODE_EXC: cmev_mode_rank = 3'h2;
			MODE_INT3: cmev_mode_rank = 3'h3;
			MODE_INT2: cmev_mode_rank = 3'h4;
			MODE_INT1: cmev_mode_rank = 3'h5;
			MODE_INT0: cmev_mode_rank = 3'h6;
			default: cmev_mode_rank = RANK_NONE;
		endcase
	endfunction

endpackage

`default_nettype wire

// ### rtl/cmev_prio_pick.sv
`default_nettype none

module cmev_prio_pick #(
	parameter int N = 9
) (
	// Requests, index 0 highest priority
	input wire logic [N-1:0] req,
	// Grant
	output logic any,
	output logic [N-1:0] grant
);

	// ==========================================================
	// Lowest set index wins
	always_comb begin
		grant = '0;
		any = |req;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				grant = '0;
				grant[i] = 1'b1; // RULE19
			end
		end
	end

endmodule

`default_nettype wire

// ### dv/cmev_assertions.sv
`default_nettype none

module cmev_assertions (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Register port
	input wire logic sys_req,
	input wire logic [9:0] sys_addr,
	input wire logic sys_done,
	input wire logic sys_fault,
	// Events
	input wire logic irq_ack,
	input wire logic [3:0] irq_ack_level,
	input wire logic redirect_valid,
	input wire logic [31:0] redirect_pc,
	input wire logic push_valid,
	// State
	input wire logic [31:0] status_word,
	input wire logic privileged
);
	timeunit 1ns;
	timeprecision 1ps;
	import cmev_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// ==========================================================
	// Register port
	AST_ACC_ANSWER: assert property (sys_req |=> sys_done != sys_fault)
		else $error("register access answer wrong");
	AST_ACC_ALIGN: assert property (sys_req && sys_addr[1:0] != 2'h0 |=> sys_fault)
		else $error("misaligned access not refused");
	AST_APP_BLOCK: assert property (sys_req && status_word[24:22] == MODE_APP
		&& !status_word[BIT_D] && sys_addr != 10'h000 |=> sys_fault)
		else $error("application access not refused");
	AST_PRIV_LAG: assert property (privileged ==
		($past(status_word[24:22]) != MODE_APP || $past(status_word[BIT_D])))
		else $error("privilege flag wrong");

	// ==========================================================
	// Reset
	AST_RESET_STATE: assert property ($rose(rst_b) |->
		status_word == STATUS_RESET && privileged)
		else $error("reset state wrong");
	AST_BOOT_FETCH: assert property ($rose(rst_b) |->
		##[1:4] (redirect_valid && redirect_pc == RESET_ADDR))
		else $error("boot fetch missing");

	// ==========================================================
	// Events
	AST_IRQ_TAKE: assert property (irq_ack |->
		redirect_valid && push_valid && $onehot(irq_ack_level))
		else $error("interrupt accept incomplete");
	AST_IRQ_MODE: assert property (irq_ack |->
		irq_ack_level == 4'h1 << (status_word[24:22] - 3'h2))
		else $error("interrupt mode wrong");
	AST_IRQ_RANK: assert property (irq_ack |->
		status_word[24:22] > $past(status_word[24:22]))
		else $error("interrupt pre-empted higher mode");
	AST_IRQ_MASK: assert property (irq_ack |->
		(status_word[20:17] | ~((irq_ack_level << 1) - 4'h1)) == 4'hf)
		else $error("lower masks not set");
	AST_DBG_ENTRY: assert property ($rose(status_word[BIT_D]) |->
		status_word[20:17] == 4'hf && redirect_valid && !push_valid)
		else $error("debug entry wrong");
	AST_DBG_EXIT: assert property ($fell(status_word[BIT_D]) |->
		redirect_valid && !push_valid)
		else $error("debug exit wrong");
endmodule

`default_nettype wire

// ### dv/cmev_irq_ctrl.sv
`default_nettype none

module cmev_irq_ctrl #(
	parameter logic [55:0] AUTOVEC = {14'h0340, 14'h0180, 14'h0140, 14'h0200}
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Interrupt lines
	input wire logic [3:0] line_req,
	// Core side
	input wire logic irq_ack,
	input wire logic [3:0] irq_ack_level,
	output logic [3:0] irq_req,
	output logic [13:0] irq_offset
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pending;

	// ==========================================================
	// Requests stay pending until the core accepts them
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pending <= 4'h0;
		end else begin
			pending <= (pending | line_req) & ~({4{irq_ack}} & irq_ack_level);
		end
	end
	assign irq_req = pending;

	// Highest pending level wins; inverted level 0 vector when idle
	always_comb begin
		irq_offset = ~AUTOVEC[13:0];
		for (int k = 0; k < 4; k++) begin
			if (pending[k]) begin
				irq_offset = AUTOVEC[k*14 +: 14];
			end
		end
	end
endmodule

`default_nettype wire

// ### dv/test_cpu_mode_and_event_vectoring.sv
`default_nettype none

module test_cpu_mode_and_event_vectoring;
	timeunit 1ns;
	timeprecision 1ps;
	import cmev_pkg::*;
	localparam logic [31:0] EVB = 32'h8000_0100;
	logic core_clk, rst_b, flag_we, unrec_exc, bus_err_data, bus_err_fetch, exc_req, nmi_req;
	logic dbg_req, retd_exec, ret_exec, sys_req, sys_write, irq_ack, sys_done, sys_fault;
	logic redirect_valid, push_valid, privileged, count_match;
	logic [4:0] flag_in;
	logic [13:0] exc_offset, irq_offset;
	logic [3:0] irq_req, line_req, irq_ack_level;
	logic [9:0] sys_addr;
	logic [31:0] cur_pc, bus_err_addr, dbg_handler, ret_status, ret_pc, sys_wdata, sys_rdata;
	logic [31:0] redirect_pc, push_status, push_pc, status_word, rd;
	int fails = 0;
	int checks_done = 0;

	always #4 core_clk = ~core_clk;

	cpu_mode_and_event_vectoring u_cpu_mode_and_event_vectoring (.core_clk, .rst_b, .flag_we,
		.flag_in, .cur_pc, .unrec_exc, .bus_err_data, .bus_err_fetch, .bus_err_addr, .exc_req,
		.exc_offset, .nmi_req, .irq_req, .irq_offset, .irq_ack, .irq_ack_level, .dbg_req,
		.dbg_handler, .retd_exec, .ret_exec, .ret_status, .ret_pc, .sys_req, .sys_write, .sys_addr,
		.sys_wdata, .sys_rdata, .sys_done, .sys_fault, .redirect_valid, .redirect_pc, .push_valid,
		.push_status, .push_pc, .status_word, .privileged, .count_match);

	cmev_irq_ctrl u_cmev_irq_ctrl (.core_clk, .rst_b, .line_req, .irq_ack, .irq_ack_level,
		.irq_req, .irq_offset);

	// ==========================================================
	// Helpers
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic acc(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic flt);
		sys_req = 1'b1;
		sys_write = wr;
		sys_addr = a;
		sys_wdata = d;
		@(negedge core_clk);
		sys_req = 1'b0;
		chk("sys_fault", {31'h0, sys_fault}, {31'h0, flt});
		chk("sys_done", {31'h0, sys_done}, {31'h0, !flt});
		rd = sys_rdata;
		@(negedge core_clk);
	endtask

	task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0, 1'b0);
		chk("sr_rdata", rd, exp);
	endtask

	task automatic wait_redir(input logic [31:0] exp);
		int n = 0;
		@(negedge core_clk);
		while (redirect_valid !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		chk("redirect_valid", {31'h0, redirect_valid}, 32'h1);
		chk("redirect_pc", redirect_pc, exp);
	endtask

	task automatic do_reset;
		rst_b = 1'b0;
		repeat (5) @(negedge core_clk);
		rst_b = 1'b1;
		wait_redir(RESET_ADDR);
		@(negedge core_clk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		chk("status_word", status_word, STATUS_RESET);
		chk("privileged", {31'h0, privileged}, 32'h1);
		flag_we = 1'b1;
		flag_in = 5'h15;
		@(negedge core_clk);
		flag_we = 1'b0;
		chk("status_word", status_word, STATUS_RESET | 32'h15);
		do_reset();
		chk("status_word", status_word, STATUS_RESET);
	endtask

	task automatic t_regs;
		logic [9:0] rwa [6] = '{ADDR_EVBASE, ADDR_CALLBASE, ADDR_CTRL, ADDR_DBG_STATUS,
			ADDR_DBG_PC, ADDR_COMPARE};
		logic [9:0] roa [6] = '{ADDR_CFG0, ADDR_CFG1, ADDR_RSV_A_LO, ADDR_RSV_B_HI,
			ADDR_OWN_LO, 10'h014};
		logic [31:0] rov [6] = '{CFG0_VALUE, CFG1_VALUE, 32'h0, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 6; i++) begin
			acc(1'b1, rwa[i], 32'h5a00_0000 | i, 1'b0);
			rdchk(rwa[i], 32'h5a00_0000 | i);
			acc(1'b1, roa[i], 32'hffff_ffff, 1'b0);
			rdchk(roa[i], rov[i]);
		end
		acc(1'b0, 10'h006, 32'h0, 1'b1);
		acc(1'b1, ADDR_COUNT, 32'h0, 1'b0);
		acc(1'b1, ADDR_COMPARE, 32'h10, 1'b0);
		repeat (20) @(negedge core_clk);
		chk("count_match", {31'h0, count_match}, 32'h1);
	endtask

	task automatic t_app;
		acc(1'b1, ADDR_EVBASE, EVB, 1'b0);
		acc(1'b1, ADDR_STATUS, 32'h0, 1'b0);
		acc(1'b0, ADDR_EVBASE, 32'h0, 1'b1);
		acc(1'b1, ADDR_STATUS, 32'h01c0_0003, 1'b0);
		chk("status_word", status_word, 32'h3);
		chk("privileged", {31'h0, privileged}, 32'h0);
		dbg_req = 1'b1;
		wait_redir(dbg_handler);
		dbg_req = 1'b0;
		chk("push_valid", {31'h0, push_valid}, 32'h0);
		chk("status_word", status_word & 32'h041e_0000, 32'h041e_0000);
		rdchk(ADDR_EVBASE, EVB);
		acc(1'b1, ADDR_STATUS, status_word & ~32'h0404_0000, 1'b0);
		chk("status_word", status_word & 32'h041e_0000, 32'h041a_0000);
		retd_exec = 1'b1;
		wait_redir(cur_pc);
		retd_exec = 1'b0;
		chk("status_word", status_word, 32'h3);
		@(negedge core_clk);
		chk("privileged", {31'h0, privileged}, 32'h0);
	endtask

	task automatic t_irq;
		acc(1'b1, ADDR_EVBASE, EVB, 1'b0);
		acc(1'b1, ADDR_STATUS, 32'h0040_0000, 1'b0);
		line_req = 4'h2;
		@(negedge core_clk);
		line_req = 4'h0;
		wait_redir(EVB | 32'h0140);
		chk("irq_ack_level", {28'h0, irq_ack_level}, 32'h2);
		chk("push_status", push_status, 32'h0040_0000);
		chk("push_pc", push_pc, cur_pc);
		chk("status_word", status_word & 32'h01de_0000, 32'h00c6_0000);
		line_req = 4'h1;
		@(negedge core_clk);
		line_req = 4'h0;
		repeat (10) @(negedge core_clk);
		chk("status_word", status_word & 32'h01c0_0000, 32'h00c0_0000);
		line_req = 4'h8;
		@(negedge core_clk);
		line_req = 4'h0;
		wait_redir(EVB | 32'h0340);
		chk("status_word", status_word & 32'h01de_0000, 32'h015e_0000);
		ret_status = 32'h00c6_0000;
		ret_pc = 32'h0000_0400;
		ret_exec = 1'b1;
		wait_redir(32'h0000_0400);
		ret_exec = 1'b0;
		chk("status_word", status_word, 32'h00c6_0000);
	endtask

	task automatic t_exc;
		acc(1'b1, ADDR_EVBASE, EVB, 1'b0);
		bus_err_addr = 32'h2000_0010;
		{unrec_exc, bus_err_data, bus_err_fetch, nmi_req} = 4'hf;
		wait_redir(EVB | OFF_UNREC);
		unrec_exc = 1'b0;
		wait_redir(EVB | OFF_BERR_D);
		bus_err_data = 1'b0;
		wait_redir(EVB | OFF_BERR_I);
		bus_err_fetch = 1'b0;
		chk("status_word", status_word & 32'h01ff_0000, 32'h01bf_0000);
		wait_redir(EVB | OFF_NMI);
		nmi_req = 1'b0;
		chk("status_word", status_word & 32'h01c0_0000, 32'h01c0_0000);
		rdchk(ADDR_BUS_FAULT, 32'h2000_0010);
		rdchk(ADDR_CAUSE, {18'h0, OFF_BERR_I});
		acc(1'b1, ADDR_STATUS, 32'h0040_0000, 1'b0);
		exc_offset = 14'h0020;
		exc_req = 1'b1;
		wait_redir(EVB | 32'h0020);
		exc_req = 1'b0;
		chk("status_word", status_word & 32'h01ff_0000, 32'h01bf_0000);
		rdchk(ADDR_CAUSE, 32'h0000_0020);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		{core_clk, rst_b, flag_we, unrec_exc, bus_err_data, bus_err_fetch, exc_req} = '0;
		{nmi_req, dbg_req, retd_exec, ret_exec, sys_req, sys_write, flag_in} = '0;
		{exc_offset, line_req, sys_addr, bus_err_addr, ret_status, ret_pc, sys_wdata} = '0;
		cur_pc = 32'h0000_1234;
		dbg_handler = 32'h8000_2000;
		do_reset();
		t_reset();
		t_regs();
		t_app();
		do_reset();
		t_irq();
		do_reset();
		t_exc();
		end_sim();
	end

	initial begin
		#100000;
		fails++;
		end_sim();
	end
endmodule

bind cpu_mode_and_event_vectoring cmev_assertions u_cmev_assertions (.core_clk, .rst_b,
	.sys_req, .sys_addr, .sys_done, .sys_fault, .irq_ack, .irq_ack_level, .redirect_valid,
	.redirect_pc, .push_valid, .status_word, .privileged);

`default_nettype wire
